// ===== inc/ltd_pkg.sv
// Constants, types and a helper function for the low-power tamper detector
package ltd_pkg;

  // Widths
  localparam int SAMPLE_W   = 16;
  localparam int NUM_PHASES = 3;
  localparam int CNT_W      = 8;
  localparam int FIELD_W    = 5;
  localparam int TGT_W      = 6;
  localparam int DATA_W     = 8;
  localparam int ADDR_W     = 16;

  // Register offsets and reset values
  localparam logic [ADDR_W-1:0] ADDR_THRESH_PERIOD = 16'hec00;
  localparam logic [ADDR_W-1:0] ADDR_RETAINED      = 16'hec01;
  localparam logic [DATA_W-1:0] THRESH_PERIOD_RST  = 8'h00;
  localparam logic [DATA_W-1:0] RETAINED_RST       = 8'h00;

  // Field positions
  localparam int PERIOD_LSB         = 3;
  localparam int PERIOD_MSB         = 7;
  localparam int THR_LSB            = 0;
  localparam int THR_MSB            = 2;
  localparam int NO_TAMPER_DIS_BIT  = 2;

  // Threshold select codes and their peak levels in gain-one sample codes
  localparam logic [2:0] THR_71MV   = 3'h0;
  localparam logic [2:0] THR_1MV    = 3'h3;
  localparam logic [2:0] THR_0471MV = 3'h7;
  localparam logic signed [SAMPLE_W-1:0] LVL_71MV     = 16'sh19b5;
  localparam logic signed [SAMPLE_W-1:0] LVL_1MV      = 16'sh005d;
  localparam logic signed [SAMPLE_W-1:0] LVL_0471MV   = 16'sh002c;
  localparam logic signed [SAMPLE_W-1:0] LVL_RESERVED = 16'sh7fff;

  // Period offsets in 20 ms units, and the hit-count offset in excursions
  localparam logic [TGT_W-1:0] DUAL_PERIOD_OFS   = 6'h0a;
  localparam logic [TGT_W-1:0] SINGLE_PERIOD_OFS = 6'h01;
  localparam logic [TGT_W-1:0] HIT_OFS           = 6'h01;

  // Period unit timing
  localparam int UNIT_TIME_NS    = 20000000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int UNIT_CYCLES_DEF = UNIT_TIME_NS / CLK_PERIOD_NS;

  // Mode pin encodings {hi, lo}
  localparam logic [1:0] MODE_MEAN  = 2'h0;
  localparam logic [1:0] MODE_FULL  = 2'h1;
  localparam logic [1:0] MODE_WATCH = 2'h2;
  localparam logic [1:0] MODE_SLEEP = 2'h3;

  typedef enum logic [1:0] {ST_OFF, ST_MEASURE, ST_DONE} ltd_state_type;

  typedef struct packed {
    logic              cs;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ltd_reg_req_type;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] phase_c_pos_input;
    logic signed [SAMPLE_W-1:0] phase_b_pos_input;
    logic signed [SAMPLE_W-1:0] phase_a_pos_input;
  } ltd_phase_samples_type;

  // Threshold code to peak level; reserved codes never trip
  function automatic logic signed [SAMPLE_W-1:0] ltd_level(input logic [2:0] code);
    case (code)
      THR_71MV:   ltd_level = LVL_71MV;
      THR_1MV:    ltd_level = LVL_1MV;
      THR_0471MV: ltd_level = LVL_0471MV;
      default:    ltd_level = LVL_RESERVED;
    endcase
  endfunction

endpackage

// ===== core/ltd_excursion_cnt.sv
// Per-phase peak comparator and excursion counter
`timescale 1ns/10ps
module ltd_excursion_cnt
  import ltd_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       clr_i,
  input  wire logic                       sample_valid_i,
  input  wire logic signed [SAMPLE_W-1:0] sample_i,
  input  wire logic signed [SAMPLE_W-1:0] level_i,
  output logic         [CNT_W-1:0]        count_o
);

  logic             above_r;
  logic [CNT_W-1:0] count_r;

  // Peak comparison on the positive terminal sample only
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || clr_i) begin
      above_r <= 1'b0;
    end else if (sample_valid_i) begin
      above_r <= (sample_i > level_i);
    end
  end

  // One count per rising excursion, saturating
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || clr_i) begin
      count_r <= '0;
    end else if (sample_valid_i && (sample_i > level_i) && !above_r && (count_r != '1)) begin
      count_r <= count_r + CNT_W'(1);
    end
  end

  assign count_o = count_r;

  a_count_single_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !clr_i |=> (count_r == $past(count_r)) || (count_r == $past(count_r) + CNT_W'(1)))
    else $error("excursion counter moved by more than one");

endmodule

// ===== core/ltd_period_timer.sv
// Measurement period timer counting 20 ms units
`timescale 1ns/10ps
module ltd_period_timer
  import ltd_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = UNIT_CYCLES_DEF
)(
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             run_i,
  input  wire logic [TGT_W-1:0] target_i,
  output logic                  reached_o
);

  logic [31:0]      tick_r;
  logic [TGT_W-1:0] units_r;

  // Cycle prescaler and unit counter, both cleared while idle
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !run_i) begin
      tick_r  <= '0;
      units_r <= '0;
    end else if (tick_r == 32'(UNIT_CYCLES - 1)) begin
      tick_r <= '0;
      if (units_r != '1) begin
        units_r <= units_r + TGT_W'(1);
      end
    end else begin
      tick_r <= tick_r + 32'd1;
    end
  end

  assign reached_o = run_i && (units_r >= target_i);

endmodule

// ===== core/ltd_tamper_detector.sv
// Low-power tamper detector: mode decode, registers, measurement and pins
`timescale 1ns/10ps
module ltd_tamper_detector
  import ltd_pkg::*;
#(
  parameter int unsigned PERIOD_UNIT_CYCLES = UNIT_CYCLES_DEF
)(
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  mode_select_hi_i,
  input  wire logic                  mode_select_lo_i,
  input  wire ltd_reg_req_type       reg_req_i,
  output logic [DATA_W-1:0]          reg_rdata_o,
  input  wire logic                  sample_valid_i,
  input  wire ltd_phase_samples_type phase_samples_i,
  output logic                       tamper_irq_n_o,
  output logic                       no_tamper_irq_n_o
);

  logic [1:0]                 mode_sel;
  logic                       in_full;
  logic                       in_watch;
  logic                       in_sleep;
  logic [DATA_W-1:0]          tamper_threshold_period_r;
  logic [DATA_W-1:0]          retained_options_r;
  logic                       tamper_only_r;
  logic [DATA_W-1:0]          reg_rdata_r;
  logic [DATA_W-1:0]          rdata_nxt;
  ltd_state_type              state_r;
  ltd_state_type              state_nxt;
  logic [FIELD_W-1:0]         period_count_field;
  logic [2:0]                 threshold_select_field;
  logic signed [SAMPLE_W-1:0] level;
  logic [TGT_W-1:0]           period_target;
  logic [CNT_W-1:0]           hit_target;
  logic                       period_done;
  logic                       counters_clr;
  logic                       timer_run;
  logic [NUM_PHASES-1:0]      phase_hit;
  logic                       any_hit;
  logic                       tamper_irq_n_r;
  logic                       no_tamper_irq_n_r;
  logic                       finish_tamper;
  logic                       finish_outage;
  logic signed [SAMPLE_W-1:0] samples [NUM_PHASES];
  logic [CNT_W-1:0]           counts  [NUM_PHASES];
  logic [31:0]                meas_cycles_r;

  // Power mode decode from the two mode pins
  assign mode_sel = {mode_select_hi_i, mode_select_lo_i};
  assign in_full  = (mode_sel == MODE_FULL);
  assign in_watch = (mode_sel == MODE_WATCH);
  assign in_sleep = (mode_sel == MODE_SLEEP);

  // Register fields
  assign period_count_field     = tamper_threshold_period_r[PERIOD_MSB:PERIOD_LSB];
  assign threshold_select_field = tamper_threshold_period_r[THR_MSB:THR_LSB];

  // Threshold write; survives every mode change, only reset clears it
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tamper_threshold_period_r <= THRESH_PERIOD_RST;
    end else if (reg_req_i.cs && reg_req_i.we && in_full &&
                 reg_req_i.addr == ADDR_THRESH_PERIOD) begin
      tamper_threshold_period_r <= reg_req_i.wdata;
    end
  end

  // Option register write; retained like the threshold register
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      retained_options_r <= RETAINED_RST;
    end else if (reg_req_i.cs && reg_req_i.we && in_full &&
                 reg_req_i.addr == ADDR_RETAINED) begin
      retained_options_r <= reg_req_i.wdata;
    end
  end

  // Sub-mode: set by writing the disable bit, back to dual-pin after sleep
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tamper_only_r <= 1'b0;
    end else if (in_sleep) begin
      tamper_only_r <= 1'b0;
    end else if (reg_req_i.cs && reg_req_i.we && in_full &&
                 reg_req_i.addr == ADDR_RETAINED) begin
      tamper_only_r <= reg_req_i.wdata[NO_TAMPER_DIS_BIT];
    end
  end

  // Read mux; port is dead outside full operation, unmapped reads zero
  always_comb begin
    rdata_nxt = '0;
    if (reg_req_i.cs && !reg_req_i.we && in_full) begin
      case (reg_req_i.addr)
        ADDR_THRESH_PERIOD: rdata_nxt = tamper_threshold_period_r;
        ADDR_RETAINED:      rdata_nxt = retained_options_r;
        default:            rdata_nxt = '0;
      endcase
    end
  end

  // Read data register, valid the cycle after the request
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_r <= '0;
    end else begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = reg_rdata_r;

  // Threshold level, in gain-one sample codes
  assign level = ltd_level(threshold_select_field);

  // Period length and hit target
  assign period_target = tamper_only_r ?
                         TGT_W'(period_count_field) + SINGLE_PERIOD_OFS :
                         TGT_W'(period_count_field) + DUAL_PERIOD_OFS;
  assign hit_target    = CNT_W'(period_count_field) + CNT_W'(HIT_OFS);

  // Counters cleared while outside the measurement; they run through done
  assign counters_clr = (state_r == ST_OFF);
  assign timer_run    = (state_r != ST_OFF);

  // Phase sample unpacking
  assign samples[0] = phase_samples_i.phase_a_pos_input;
  assign samples[1] = phase_samples_i.phase_b_pos_input;
  assign samples[2] = phase_samples_i.phase_c_pos_input;

  // One excursion counter per phase
  generate
    for (genvar p = 0; p < NUM_PHASES; p++) begin : g_phase
      ltd_excursion_cnt u_exc (
        .clk_i          (clk_i),
        .rst_b_i        (rst_b_i),
        .clr_i          (counters_clr),
        .sample_valid_i (sample_valid_i),
        .sample_i       (samples[p]),
        .level_i        (level),
        .count_o        (counts[p])
      );
      assign phase_hit[p] = (counts[p] >= hit_target);
    end
  endgenerate

  assign any_hit = |phase_hit;

  // Measurement period timer
  ltd_period_timer #(
    .UNIT_CYCLES (PERIOD_UNIT_CYCLES)
  ) u_timer (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .run_i     (timer_run),
    .target_i  (period_target),
    .reached_o (period_done)
  );

  // Outcome at end of period; tamper-only keeps checking after it
  assign finish_tamper = (state_r == ST_MEASURE) && in_watch && period_done && any_hit;
  assign finish_outage = (state_r == ST_MEASURE) && in_watch && period_done && !any_hit &&
                         !tamper_only_r;

  // Measurement sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (in_watch) begin
          state_nxt = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        if (!in_watch) begin
          state_nxt = ST_OFF;
        end else if (finish_tamper || finish_outage) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!in_watch) begin
          state_nxt = ST_OFF;
        end
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Tamper pin: low from the verdict until the mode is left
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !in_watch) begin
      tamper_irq_n_r <= 1'b1;
    end else if (finish_tamper) begin
      tamper_irq_n_r <= 1'b0;
    end
  end

  // No-tamper pin: dual-pin sub-mode only
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !in_watch) begin
      no_tamper_irq_n_r <= 1'b1;
    end else if (finish_outage) begin
      no_tamper_irq_n_r <= 1'b0;
    end
  end

  assign tamper_irq_n_o    = tamper_irq_n_r;
  assign no_tamper_irq_n_o = no_tamper_irq_n_r;

  // Cycles spent measuring since entry; check helper only, drives no output.
  // Cleared while off so every new entry starts a fresh period count.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || (state_r == ST_OFF)) begin
      meas_cycles_r <= '0;
    end else if (state_r == ST_MEASURE) begin
      meas_cycles_r <= meas_cycles_r + 32'd1;
    end
  end

  // Checks
  a_reset_field_zero: assert property (@(posedge clk_i)
    !rst_b_i |=> (tamper_threshold_period_r == THRESH_PERIOD_RST) && !tamper_only_r)
    else $error("period field not zero after reset");

  a_port_off_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (reg_req_i.cs && reg_req_i.we && !in_full) |=>
      $stable(tamper_threshold_period_r) && $stable(retained_options_r))
    else $error("register changed outside full operation");

  a_port_off_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !in_full |=> (reg_rdata_o == '0))
    else $error("read data returned outside full operation");

  a_tamper_verdict: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ((state_r == ST_MEASURE) && in_watch && period_done && any_hit) ##1 in_watch |->
      !tamper_irq_n_o && no_tamper_irq_n_o && (state_r == ST_DONE))
    else $error("tamper pin not driven on hit");

  a_outage_verdict: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ((state_r == ST_MEASURE) && in_watch && period_done && !any_hit && !tamper_only_r) ##1 in_watch |->
      !no_tamper_irq_n_o && tamper_irq_n_o)
    else $error("no-tamper pin not driven on outage");

  a_pins_exclusive: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tamper_irq_n_o || no_tamper_irq_n_o)
    else $error("both interrupt pins low");

  a_single_pin_only: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tamper_only_r |-> no_tamper_irq_n_o)
    else $error("no-tamper pin driven in tamper-only sub-mode");

  a_pin_held_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!tamper_irq_n_o && in_watch) ##1 in_watch |-> !tamper_irq_n_o)
    else $error("tamper pin released while still in watch mode");

  a_pin_release: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !in_watch |=> tamper_irq_n_o && no_tamper_irq_n_o)
    else $error("pin still low after leaving watch mode");

  a_sleep_default: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    in_sleep ##1 in_watch[*2] |-> !tamper_only_r)
    else $error("sub-mode not back to default after sleep");

  a_entry_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_r == ST_OFF) |=> (counts[0] == '0) && (counts[1] == '0) && (counts[2] == '0))
    else $error("phase counters not cleared on entry");

  a_period_dual: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!tamper_only_r && (period_count_field == 5'h02)) |-> (period_target == 6'h0c))
    else $error("dual-pin period length wrong");

  // Period timing checks, worked out from the field and the unit length
  a_period_length: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ((state_r == ST_MEASURE) && (state_nxt == ST_DONE) && !tamper_only_r) |->
      (meas_cycles_r == (32'(period_count_field) + 32'(DUAL_PERIOD_OFS)) * 32'(PERIOD_UNIT_CYCLES)))
    else $error("dual-pin measurement period has wrong length");

  a_single_min_wait: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ((state_r == ST_MEASURE) && (state_nxt == ST_DONE) && tamper_only_r) |->
      (meas_cycles_r >= (32'(period_count_field) + 32'(SINGLE_PERIOD_OFS)) * 32'(PERIOD_UNIT_CYCLES)))
    else $error("tamper-only verdict before the minimum wait");

  a_no_early_verdict: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !period_done |=> tamper_irq_n_o && no_tamper_irq_n_o)
    else $error("interrupt pin driven before the period ended");

  // Register retention and sub-mode selection
  a_field_retained: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(reg_req_i.cs && reg_req_i.we && in_full) |=>
      $stable(tamper_threshold_period_r) && $stable(retained_options_r))
    else $error("retained register changed without a write");

  a_sub_mode_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (reg_req_i.cs && reg_req_i.we && in_full && (reg_req_i.addr == ADDR_RETAINED)) |=>
      (tamper_only_r == retained_options_r[NO_TAMPER_DIS_BIT]))
    else $error("sub-mode does not follow the pin disable bit");

  c_tamper_seen: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(tamper_irq_n_o) && !tamper_only_r);

  c_outage_seen: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(no_tamper_irq_n_o));

  c_single_tamper: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(tamper_irq_n_o) && tamper_only_r);

  c_sleep_return: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    in_sleep ##1 in_watch);

  c_write_refused: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    reg_req_i.cs && reg_req_i.we && !in_full);

endmodule

// ===== testbench/ltd_ctrl_model.sv
// Controller model: drives the mode pins and reacts to the verdict pins
`timescale 1ns/10ps
module ltd_ctrl_model
  import ltd_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] mode_req_i,
  input  wire logic       react_i,
  input  wire logic       tamper_irq_n_i,
  input  wire logic       no_tamper_irq_n_i,
  output logic            mode_select_hi_o,
  output logic            mode_select_lo_o
);
  logic [1:0] mode_r;

  // Follow the requested mode; when reacting, leave watch mode on a verdict
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mode_r <= mode_req_i;
    end else if (!react_i) begin
      mode_r <= mode_req_i;
    end else if (mode_r == MODE_WATCH && !no_tamper_irq_n_i) begin
      mode_r <= MODE_SLEEP;
    end else if (mode_r == MODE_WATCH && !tamper_irq_n_i) begin
      mode_r <= MODE_MEAN;
    end
  end

  // Pins {hi, lo}; current gain is taken as 1 whenever watch mode is used
  assign mode_select_hi_o = mode_r[1];
  assign mode_select_lo_o = mode_r[0];
endmodule

// ===== testbench/ltd_tamper_detector_test.sv
// Self-checking testbench for the low-power tamper detector
`timescale 1ns/10ps
module ltd_tamper_detector_test;
  import ltd_pkg::*;
  localparam int U = 20;
  logic                  clk_i       = 1'b0;
  logic                  rst_b_i     = 1'b0;
  logic [1:0]            mode_req    = MODE_FULL;
  logic                  react       = 1'b0;
  logic                  mode_hi;
  logic                  mode_lo;
  ltd_reg_req_type       req         = '0;
  logic [DATA_W-1:0]     rdata;
  logic                  valid       = 1'b0;
  ltd_phase_samples_type smp         = '0;
  logic                  tamper_n;
  logic                  no_tamper_n;
  logic [7:0]            pins;
  int                    failures    = 0;
  int                    check_count = 0;
  int                    cyc         = 0;
  // Scenario table: threshold code, period field, amplitude, excursions, verdict
  logic [2:0]            t_code [6]  = '{3'h3, 3'h3, 3'h3, 3'h0, 3'h7, 3'h1};
  logic [4:0]            t_fld  [6]  = '{5'h02, 5'h02, 5'h02, 5'h00, 5'h00, 5'h00};
  logic [15:0]           t_amp  [6]  = '{LVL_1MV + 16'sh0001, LVL_1MV + 16'sh0001, LVL_1MV,
                                         LVL_71MV + 16'sh0001, LVL_0471MV + 16'sh0001, 16'h7ffe};
  int                    t_n    [6]  = '{3, 2, 5, 1, 1, 1};
  logic [7:0]            t_exp  [6]  = '{8'h01, 8'h02, 8'h02, 8'h01, 8'h01, 8'h02};

  assign pins = {6'h00, tamper_n, no_tamper_n};

  ltd_tamper_detector #(.PERIOD_UNIT_CYCLES(U)) ltd_tamper_detector_inst (
    .clk_i             (clk_i),
    .rst_b_i           (rst_b_i),
    .mode_select_hi_i  (mode_hi),
    .mode_select_lo_i  (mode_lo),
    .reg_req_i         (req),
    .reg_rdata_o       (rdata),
    .sample_valid_i    (valid),
    .phase_samples_i   (smp),
    .tamper_irq_n_o    (tamper_n),
    .no_tamper_irq_n_o (no_tamper_n)
  );

  ltd_ctrl_model ltd_ctrl_model_inst (
    .clk_i             (clk_i),
    .rst_b_i           (rst_b_i),
    .mode_req_i        (mode_req),
    .react_i           (react),
    .tamper_irq_n_i    (tamper_n),
    .no_tamper_irq_n_i (no_tamper_n),
    .mode_select_hi_o  (mode_hi),
    .mode_select_lo_o  (mode_lo)
  );

  // Clock generation
  always #5 clk_i = ~clk_i;

  // Cycle count and hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // One register access; read data is checked in the cycle it stands, then one idle cycle
  task automatic acc(input logic we, input logic [15:0] a, input logic [7:0] d, input logic [7:0] exp);
    req = '{cs: 1'b1, we: we, addr: a, wdata: d};
    ticks(1);
    req = '0;
    if (!we) chk(rdata, exp);
    ticks(1);
  endtask

  task automatic setmode(input logic [1:0] m);
    mode_req = m;
    ticks(3);
  endtask

  // Rising excursions on one phase, each followed by a sample that is not above
  task automatic hits(input int ph, input logic [15:0] amp, input int n);
    ltd_phase_samples_type s;
    s = '0;
    s[ph*16 +: 16] = amp;
    valid = 1'b1;
    repeat (n) begin
      smp = s;
      ticks(1);
      smp = '0;
      ticks(1);
    end
    valid = 1'b0;
    ticks(1);
  endtask

  task automatic wait_low(input int max);
    for (int i = 0; i < max && pins == 8'h03; i++) ticks(1);
  endtask

  // Dual-pin measurement: no verdict just before the period ends, then the right pin held low
  task automatic run_watch(input logic [2:0] code, input logic [4:0] fld, input int ph,
                           input logic [15:0] amp, input int n, input logic [7:0] exp);
    int t0;
    acc(1'b1, ADDR_THRESH_PERIOD, {fld, code}, 8'h00);
    mode_req = MODE_WATCH;
    t0 = cyc;
    ticks(3);
    hits(ph, amp, n);
    ticks((fld + 10) * U - 3 - (cyc - t0));
    chk(pins, 8'h03);
    wait_low(12);
    chk(pins, exp);
    ticks(15);
    chk(pins, exp);
    setmode(MODE_FULL);
    chk(pins, 8'h03);
  endtask

  // Main sequence
  initial begin
    ticks(8);
    rst_b_i = 1'b1;
    ticks(1);
    chk(pins, 8'h03);
    acc(1'b0, ADDR_THRESH_PERIOD, 8'h00, 8'h00);
    acc(1'b0, ADDR_RETAINED, 8'h00, 8'h00);
    acc(1'b1, ADDR_RETAINED, 8'h5a, 8'h00);
    acc(1'b0, ADDR_RETAINED, 8'h00, 8'h5a);
    acc(1'b1, 16'hec02, 8'hff, 8'h00);
    acc(1'b0, 16'hec02, 8'h00, 8'h00);
    acc(1'b1, ADDR_RETAINED, 8'h00, 8'h00);
    acc(1'b1, ADDR_THRESH_PERIOD, 8'h13, 8'h00);
    setmode(MODE_WATCH);
    acc(1'b1, ADDR_THRESH_PERIOD, 8'hff, 8'h00);
    acc(1'b0, ADDR_THRESH_PERIOD, 8'h00, 8'h00);
    setmode(MODE_FULL);
    acc(1'b0, ADDR_THRESH_PERIOD, 8'h00, 8'h13);
    for (int i = 0; i < 6; i++) begin
      run_watch(t_code[i], t_fld[i], i % 3, t_amp[i], t_n[i], t_exp[i]);
    end
    // Tamper-only sub-mode: silence without excursions, late excursions still count
    acc(1'b1, ADDR_RETAINED, 8'h04, 8'h00);
    acc(1'b1, ADDR_THRESH_PERIOD, 8'h0b, 8'h00);
    setmode(MODE_WATCH);
    ticks(300);
    chk(pins, 8'h03);
    hits(1, LVL_1MV + 16'sh0001, 2);
    wait_low(10);
    chk(pins, 8'h01);
    react = 1'b1;
    ticks(3);
    chk(pins, 8'h03);
    chk({6'h00, mode_hi, mode_lo}, {6'h00, MODE_MEAN});
    mode_req = MODE_SLEEP;
    react = 1'b0;
    ticks(3);
    // Back from sleep: dual-pin sub-mode again, outage reported
    setmode(MODE_WATCH);
    wait_low(11 * U + 10);
    chk(pins, 8'h02);
    react = 1'b1;
    ticks(3);
    chk({6'h00, mode_hi, mode_lo}, {6'h00, MODE_SLEEP});
    chk(pins, 8'h03);
    mode_req = MODE_FULL;
    react = 1'b0;
    ticks(3);
    acc(1'b0, ADDR_RETAINED, 8'h00, 8'h04);
    acc(1'b0, ADDR_THRESH_PERIOD, 8'h00, 8'h0b);
    results();
  end
endmodule
